// File: hdl/fbp_fetch.sv
// How it works
// - Branch target cache holds 64 fully associative taken-branch targets.
// - A target cache hit becomes the fetch address on the next cycle.
// - On a miss, next address advances by instructions just fetched.
// - Target cache is searched with the fetch address, not a branch pc.
// - Unconditional branch predicted not taken redirects fetch to its target.
// - Count-register branches predicted from its value; redirect on mismatch.
// - Count/link register targets corrected only with no update pending.
// - Decode corrections consider only the first two decode slots.
// - History table has 512 direct-mapped two-bit saturating states.
// - Condition-register branches are predicted from their history entry.
// - Every executed condition-register branch steps its entry one place.
// - Cleared history-enable config bit stops history-based prediction.
// - Cache miss starts a fill; each double word forwarded the cycle after it arrives.
// - Hits proceed during a fill; a further miss waits for its end.
// - Fill is a four-beat burst, critical double word first.
// - Each beat delivers one instruction pair, forwarded the cycle after it arrives.
// - Fetch four instructions, or two at the last pair of a block.
`timescale 1ns/100ps
`default_nettype none
`include "fbp_defs.svh"
module fbp_fetch #(
  parameter int BTC_N = `FBP_BTC_N,
  parameter int BHT_N = `FBP_BHT_N
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             cfg_bht_en,
  input  wire logic             ic_hit,
  input  wire logic             ic_miss,
  input  wire logic             iq_ready,
  input  wire fbp_pkg::fbp_dec_t dec_br,
  input  wire fbp_pkg::fbp_res_t res,
  input  wire logic             beat_valid,
  input  wire logic [63:0]      beat_data,
  output logic                  fetch_valid_r,
  output logic [31:0]           fetch_addr_r,
  output logic [2:0]            fetch_cnt_r,
  output logic                  redirect_r,
  output logic                  fill_req_r,
  output logic [31:0]           fill_addr_r,
  output logic                  fwd_valid_r,
  output logic [63:0]           fwd_pair_r,
  output logic [1:0]            fwd_idx_r
);
  import fbp_pkg::*;
  localparam int BI = $clog2(BTC_N);
  localparam int HI = $clog2(BHT_N);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  logic [BTC_N-1:0] btc_vld_r, btc_vld_nxt;
  logic [29:0]      btc_tag_r [BTC_N];
  logic [31:0]      btc_tgt_r [BTC_N];
  logic [BI-1:0]    rr_r, rr_nxt;
  fbp_hist_t        bht_r [BHT_N];
  logic [BI:0]      fnd, rfnd;
  logic             alloc, adv, redir, pt;
  logic [31:0]      redir_tgt, addr_nxt;
  logic [HI-1:0]    d_idx, r_idx;
  logic             bht_we;
  fbp_fill_t        fs_r, fs_nxt;
  logic [1:0]       beat_r, beat_nxt;
  logic             req_nxt, fwdv_nxt;
  logic [31:0]      faddr_nxt;
  logic [63:0]      fwd_nxt;
  logic [1:0]       fidx_nxt;

  // Fully associative search keyed by fetch address
  function automatic logic [BI:0] btc_find(input logic [31:0] a);
    btc_find = '0;
    for (int i = 0; i < BTC_N; i++) begin
      if (btc_vld_r[i] && btc_tag_r[i] == a[31:2]) begin
        btc_find = {1'b1, BI'(i)};
      end
    end
  endfunction

  function automatic fbp_hist_t bht_step(input fbp_hist_t s, input logic t);
    if (t) begin
      bht_step = (s == 2'h3) ? s : s + 2'h1;
    end else begin
      bht_step = (s == 2'h0) ? s : s - 2'h1;
    end
  endfunction

  function automatic logic [2:0] fetch_width(input logic [31:0] a);
    fetch_width = (a[4:3] == `FBP_TAIL_POS) ? `FBP_TAIL_W : `FBP_FETCH_W;
  endfunction

  // Decode-stage correction
  always_comb begin
    redir = 1'b0;
    redir_tgt = dec_br.target;
    pt = 1'b0;
    d_idx = dec_br.pc[HI+1:2];
    if (res.valid && res.mispred) begin
      redir = 1'b1;
      redir_tgt = res.next_pc;
    end else if (dec_br.valid && dec_br.slot < 2'h2) begin
      case (dec_br.kind)
        BK_UNCOND: begin
          redir = !dec_br.pred_taken;
        end
        BK_CTR_COND: begin
          pt = dec_br.count_register != `FBP_CTR_LAST;
          redir = pt != dec_br.pred_taken;
          redir_tgt = pt ? dec_br.target : dec_br.pc + `FBP_SEQ_STEP;
        end
        BK_CR_COND: begin
          pt = cfg_bht_en ? bht_r[d_idx][1] : dec_br.static_taken;
          redir = pt != dec_br.pred_taken;
          redir_tgt = pt ? dec_br.target : dec_br.pc + `FBP_SEQ_STEP;
        end
        BK_CTR_TGT: begin
          redir = !dec_br.ctr_pend && !dec_br.pred_taken;
          redir_tgt = dec_br.count_register;
        end
        BK_LR_TGT: begin
          redir = !dec_br.lr_pend && !dec_br.pred_taken;
          redir_tgt = dec_br.link_register;
        end
        default: begin
          redir = 1'b0;
        end
      endcase
    end
  end

  // Next fetch address
  always_comb begin
    fnd = btc_find(fetch_addr_r);
    adv = fetch_valid_r && ic_hit && iq_ready;
    addr_nxt = fetch_addr_r;
    if (redir) begin
      addr_nxt = redir_tgt;
    end else if (adv && fnd[BI]) begin
      addr_nxt = btc_tgt_r[fnd[BI-1:0]];
    end else if (adv) begin
      addr_nxt = fetch_addr_r + {27'h0, fetch_cnt_r, 2'h0};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fetch_valid_r <= 1'b0;
      fetch_addr_r  <= `FBP_RST_ADDR;
      fetch_cnt_r   <= fetch_width(`FBP_RST_ADDR);
      redirect_r    <= 1'b0;
    end else begin
      fetch_valid_r <= 1'b1;
      fetch_addr_r  <= addr_nxt;
      fetch_cnt_r   <= fetch_width(addr_nxt);
      redirect_r    <= redir;
    end
  end

  // Target cache allocation; a not-taken resolve drops a stale entry
  always_comb begin
    rfnd = btc_find(res.fetch_addr);
    btc_vld_nxt = btc_vld_r;
    rr_nxt = rr_r;
    alloc = res.valid && res.taken && !rfnd[BI];
    if (alloc) begin
      btc_vld_nxt[rr_r] = 1'b1;
      rr_nxt = rr_r + BI'(1);
    end else if (res.valid && !res.taken && rfnd[BI]) begin
      btc_vld_nxt[rfnd[BI-1:0]] = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      btc_vld_r <= '0;
      rr_r <= '0;
    end else begin
      btc_vld_r <= btc_vld_nxt;
      rr_r <= rr_nxt;
      if (alloc) begin
        btc_tag_r[rr_r] <= res.fetch_addr[31:2];
        btc_tgt_r[rr_r] <= res.target;
      end
    end
  end

  // History keeps training even while prediction from it is off
  always_comb begin
    r_idx = res.pc[HI+1:2];
    bht_we = res.valid && res.cr_dep;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < BHT_N; i++) begin
        bht_r[i] <= `FBP_BHT_INIT;
      end
    end else if (bht_we) begin
      bht_r[r_idx] <= bht_step(bht_r[r_idx], res.taken);
    end
  end

  // Line fill: one fill at a time, misses held off until it ends
  always_comb begin
    fs_nxt = fs_r;
    beat_nxt = beat_r;
    req_nxt = fill_req_r;
    faddr_nxt = fill_addr_r;
    fwdv_nxt = 1'b0;
    fwd_nxt = fwd_pair_r;
    fidx_nxt = fwd_idx_r;
    case (fs_r)
      FS_IDLE: begin
        if (fetch_valid_r && ic_miss) begin
          fs_nxt = FS_BURST;
          req_nxt = 1'b1;
          beat_nxt = 2'h0;
          faddr_nxt = {fetch_addr_r[31:3], 3'h0};
        end
      end
      FS_BURST: begin
        if (beat_valid) begin
          req_nxt = 1'b0;
          fwdv_nxt = 1'b1;
          fwd_nxt = beat_data;
          fidx_nxt = beat_r;
          beat_nxt = beat_r + 2'h1;
          if (beat_r == `FBP_BEATS) begin
            fs_nxt = FS_IDLE;
          end
        end
      end
      default: begin
        fs_nxt = FS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fs_r <= FS_IDLE;
      beat_r <= 2'h0;
      fill_req_r <= 1'b0;
      fill_addr_r <= '0;
      fwd_valid_r <= 1'b0;
      fwd_pair_r <= '0;
      fwd_idx_r <= 2'h0;
    end else begin
      fs_r <= fs_nxt;
      beat_r <= beat_nxt;
      fill_req_r <= req_nxt;
      fill_addr_r <= faddr_nxt;
      fwd_valid_r <= fwdv_nxt;
      fwd_pair_r <= fwd_nxt;
      fwd_idx_r <= fidx_nxt;
    end
  end

  property p_btc_hit;
    logic [31:0] t;
    (adv && !redir && fnd[BI], t = btc_tgt_r[fnd[BI-1:0]])
      |=> fetch_addr_r == t;
  endproperty
  a_btc_hit: assert property (p_btc_hit)
    else $error("target cache hit not used as next fetch address");
  property p_seq;
    adv && !redir && !fnd[BI] |=>
      fetch_addr_r == $past(fetch_addr_r) + {27'h0, $past(fetch_cnt_r), 2'h0};
  endproperty
  a_seq: assert property (p_seq)
    else $error("sequential advance wrong");
  property p_tail;
    fetch_valid_r |-> fetch_cnt_r == ((fetch_addr_r[4:3] == 2'h3) ? 3'h2 : 3'h4);
  endproperty
  a_tail: assert property (p_tail)
    else $error("fetch width wrong for block position");
  property p_slot;
    !res.valid && dec_br.valid && dec_br.slot >= 2'h2 |=> !redirect_r;
  endproperty
  a_slot: assert property (p_slot)
    else $error("correction from third or later decode slot");
  property p_pend;
    !res.valid && dec_br.valid && dec_br.kind == BK_LR_TGT && dec_br.lr_pend
      |=> !redirect_r;
  endproperty
  a_pend: assert property (p_pend)
    else $error("link target corrected with update pending");
  property p_uncond;
    !res.valid && dec_br.valid && dec_br.slot < 2'h2 &&
      dec_br.kind == BK_UNCOND && !dec_br.pred_taken
      |=> redirect_r && fetch_addr_r == $past(dec_br.target);
  endproperty
  a_uncond: assert property (p_uncond)
    else $error("unconditional branch not redirected");
  property p_bht_off;
    !res.valid && !cfg_bht_en && dec_br.valid && dec_br.slot < 2'h2 &&
      dec_br.kind == BK_CR_COND && dec_br.static_taken == dec_br.pred_taken
      |=> !redirect_r;
  endproperty
  a_bht_off: assert property (p_bht_off)
    else $error("history used while disabled");
  property p_bht_up;
    bht_we && res.taken && bht_r[r_idx] == 2'h2 |=> bht_r[$past(r_idx)] == 2'h3;
  endproperty
  a_bht_up: assert property (p_bht_up)
    else $error("taken state did not strengthen");
  property p_fwd;
    fs_r == FS_BURST && beat_valid
      |=> fwd_valid_r && fwd_pair_r == $past(beat_data) && !fill_req_r;
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("beat not forwarded next cycle");
  property p_burst_end;
    fwd_valid_r && fwd_idx_r == 2'h3 |-> fs_r == FS_IDLE;
  endproperty
  a_burst_end: assert property (p_burst_end)
    else $error("fill did not end after fourth beat");
  property p_one_fill;
    fs_r == FS_BURST && $past(fs_r) == FS_BURST |-> $stable(fill_addr_r);
  endproperty
  a_one_fill: assert property (p_one_fill)
    else $error("second fill started during a fill");

  property p_alloc;
    alloc |=> btc_vld_r[$past(rr_r)] && rr_r == $past(rr_r) + BI'(1);
  endproperty
  a_alloc: assert property (p_alloc)
    else $error("target cache allocation failed");

  c_hit: cover property (adv && fnd[BI]);
  c_fill: cover property (fwd_valid_r && fwd_idx_r == 2'h3);
  c_redir: cover property (redirect_r ##1 adv);
  c_hit_in_fill: cover property (fs_r == FS_BURST && adv);
endmodule
`default_nettype wire

// File: hdl/fbp_defs.svh
`ifndef FBP_DEFS_SVH
`define FBP_DEFS_SVH
`define FBP_BTC_N     64
`define FBP_BHT_N     512
`define FBP_BEATS     2'h3
`define FBP_FETCH_W   3'h4
`define FBP_TAIL_W    3'h2
`define FBP_TAIL_POS  2'h3
`define FBP_RST_ADDR  32'h0000_0100
`define FBP_BHT_INIT  2'h1
`define FBP_SEQ_STEP  32'h0000_0004
`define FBP_CTR_LAST  32'h0000_0001
`endif

// File: hdl/fbp_pkg.sv
package fbp_pkg;
  // 00 strong not-taken, 01 not-taken, 10 taken, 11 strong taken
  typedef logic [1:0] fbp_hist_t;
  typedef enum logic [2:0] {
    BK_NONE, BK_UNCOND, BK_CTR_COND, BK_CR_COND, BK_CTR_TGT, BK_LR_TGT
  } fbp_kind_t;
  typedef struct packed {
    logic        valid;
    logic [1:0]  slot;
    fbp_kind_t   kind;
    logic        pred_taken;
    logic        static_taken;
    logic [31:0] pc;
    logic [31:0] target;
    logic [31:0] count_register;
    logic [31:0] link_register;
    logic        ctr_pend;
    logic        lr_pend;
  } fbp_dec_t;
  typedef struct packed {
    logic        valid;
    logic        taken;
    logic        cr_dep;
    logic        mispred;
    logic [31:0] pc;
    logic [31:0] fetch_addr;
    logic [31:0] target;
    logic [31:0] next_pc;
  } fbp_res_t;
  typedef enum logic {FS_IDLE, FS_BURST} fbp_fill_t;
endpackage

// File: verif/fbp_cache_model.sv
`timescale 1ns/100ps
`default_nettype none
module fbp_cache_model (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        miss_en,
  input  wire logic        slow,
  input  wire logic        fill_req_r,
  input  wire logic [31:0] fill_addr_r,
  output logic             ic_hit,
  output logic             ic_miss,
  output logic             beat_valid,
  output logic [63:0]      beat_data
);
  logic       busy, done, tick;
  logic [1:0] n;
  initial beat_data = 64'h5a5a_0f0f_a5a5_f0f0;
  assign ic_miss = miss_en & ~done;
  assign ic_hit  = ~ic_miss;
  always @(posedge core_clk) begin
    tick <= ~tick;
    beat_valid <= 1'b0;
    // Idle bus toggles so stale data never passes
    beat_data <= ~beat_data;
    if (sys_rst || !miss_en) begin
      busy <= 1'b0;
      done <= 1'b0;
      n <= 2'h0;
      tick <= 1'b0;
    end else if (!busy && !done && fill_req_r) begin
      busy <= 1'b1;
    end else if (busy && (!slow || tick)) begin
      beat_valid <= 1'b1;
      beat_data <= {fill_addr_r, 30'h0, n};
      n <= n + 2'h1;
      if (n == 2'h3) begin
        busy <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/test_fetch_branch_predictor.sv
`timescale 1ns/100ps
`default_nettype none
`include "fbp_defs.svh"
module test_fetch_branch_predictor;
  import fbp_pkg::*;
  logic        core_clk, sys_rst, cfg_bht_en, iq_ready, miss_en, slow;
  logic        ic_hit, ic_miss, beat_valid, fetch_valid_r, redirect_r;
  logic        fill_req_r, fwd_valid_r, mv, m_red;
  logic [63:0] beat_data, fwd_pair_r;
  logic [31:0] fetch_addr_r, fill_addr_r, m_addr, fa, x;
  logic [31:0] s_key[64], s_tgt[64];
  logic [2:0]  fetch_cnt_r;
  logic [1:0]  fwd_idx_r;
  fbp_dec_t    dec_br;
  fbp_res_t    res;
  bit          s_v[64];
  int          failures, checks_done, k, rr, hist[512];
  fbp_fetch fbp_fetch_i (.core_clk, .sys_rst, .cfg_bht_en, .ic_hit,
    .ic_miss, .iq_ready, .dec_br, .res, .beat_valid, .beat_data,
    .fetch_valid_r, .fetch_addr_r, .fetch_cnt_r, .redirect_r, .fill_req_r,
    .fill_addr_r, .fwd_valid_r, .fwd_pair_r, .fwd_idx_r);
  fbp_cache_model fbp_cache_model_i (.core_clk, .sys_rst, .miss_en, .slow,
    .fill_req_r, .fill_addr_r, .ic_hit, .ic_miss, .beat_valid, .beat_data);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  function automatic logic [31:0] pool(logic [31:0] v);
    return 32'h100 | {24'h0, v[7:2], 2'h0};
  endfunction
  function automatic int lookup(logic [31:0] a);
    for (int i = 0; i < 64; i++) begin
      if (s_v[i] && s_key[i] == a) return i;
    end
    return -1;
  endfunction
  // Direction that decode now believes, before this edge's training
  function automatic bit pred_t();
    if (dec_br.kind == BK_CTR_COND) return dec_br.count_register != 1;
    return cfg_bht_en ? hist[dec_br.pc[10:2]] > 1
                      : dec_br.static_taken;
  endfunction
  function automatic bit dec_fix();
    if (!dec_br.valid || dec_br.slot > 1) return 0;
    case (dec_br.kind)
      BK_UNCOND:  return !dec_br.pred_taken;
      BK_CTR_COND,
      BK_CR_COND: return pred_t() != dec_br.pred_taken;
      BK_CTR_TGT: return !dec_br.pred_taken && !dec_br.ctr_pend;
      BK_LR_TGT:  return !dec_br.pred_taken && !dec_br.lr_pend;
      default:    return 0;
    endcase
  endfunction
  // A conditional now judged not taken falls through to the next word
  function automatic logic [31:0] dec_tgt();
    case (dec_br.kind)
      BK_CTR_TGT: return dec_br.count_register;
      BK_LR_TGT:  return dec_br.link_register;
      BK_UNCOND:  return dec_br.target;
      default:    return pred_t() ? dec_br.target : dec_br.pc + 32'h4;
    endcase
  endfunction
  always @(posedge core_clk) begin
    int i;
    int h;
    if (sys_rst) begin
      m_addr = `FBP_RST_ADDR;
      mv = 0;
      m_red = 0;
      rr = 0;
      foreach (hist[j]) hist[j] = `FBP_BHT_INIT;
      foreach (s_v[j]) s_v[j] = 0;
    end else begin
      i = lookup(m_addr);
      m_red = (res.valid && res.mispred) || dec_fix();
      if (res.valid && res.mispred) m_addr = res.next_pc;
      else if (dec_fix()) m_addr = dec_tgt();
      else if (mv && ic_hit && iq_ready) m_addr = i >= 0 ? s_tgt[i] :
        m_addr + (m_addr[4:3] == 2'h3 ? 8 : 16);
      mv = 1;
      if (res.valid) begin
        i = lookup(res.fetch_addr);
        if (res.taken && i < 0) begin
          s_key[rr] = res.fetch_addr;
          s_tgt[rr] = res.target;
          s_v[rr] = 1;
          rr = (rr + 1) % 64;
        end
        if (!res.taken && i >= 0) s_v[i] = 0;
        h = hist[res.pc[10:2]];
        if (res.cr_dep) hist[res.pc[10:2]] = res.taken ? (h < 3 ? h + 1 : 3)
          : (h > 0 ? h - 1 : 0);
      end
    end
  end
  task automatic cmp(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      failures++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task automatic check();
    cmp(fetch_addr_r === m_addr, "fetch address");
    cmp(redirect_r === m_red, "redirect");
    cmp(fetch_cnt_r === (m_addr[4:3] == 2'h3 ? 3'h2 : 3'h4), "count");
    if (fwd_valid_r) begin
      cmp(fwd_idx_r === k[1:0] && fwd_pair_r === {fa, 32'(k)}, "beat");
      k++;
    end
  endtask
  task automatic drive(input bit quiet);
    logic [31:0] r;
    r = rnd();
    iq_ready = r[0] | r[1];
    dec_br = '0;
    res = '0;
    if (quiet) return;
    dec_br.valid = r[2] & r[3];
    dec_br.slot = r[5:4];
    dec_br.kind = fbp_kind_t'(r[8:6] % 6);
    dec_br.pred_taken = r[9] & r[10];
    dec_br.static_taken = r[11];
    dec_br.pc = pool(r >> 1);
    dec_br.target = pool(r >> 8);
    dec_br.count_register = pool(r >> 3);
    if (dec_br.kind == BK_CTR_COND && r[12]) dec_br.count_register = 1;
    dec_br.link_register = pool(r >> 5);
    dec_br.ctr_pend = r[14];
    dec_br.lr_pend = r[15];
    r = rnd();
    res.valid = r[0] | r[1];
    res.taken = r[2];
    res.cr_dep = r[3];
    res.mispred = r[4] & r[5] & r[6];
    res.pc = pool(r >> 7);
    res.fetch_addr = r[7] ? m_addr : pool(r >> 9);
    res.target = res.fetch_addr ^ 32'h40;
    res.next_pc = pool(r >> 11);
  endtask
  task automatic fill(input bit s);
    slow = s;
    miss_en = 1;
    fa = {m_addr[31:3], 3'h0};
    k = 0;
    for (int n = 0; n < 40 && k < 4; n++) begin
      @(negedge core_clk);
      check();
      drive(1);
      if (fill_req_r) cmp(fill_addr_r === fa, "fill address");
    end
    cmp(k == 4, "beat count");
    miss_en = 0;
    $display("fill test done");
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    $display("unexpected %0t watchdog", $time);
    stop_test();
  end
  initial begin
    x = 32'd66975;
    sys_rst = 1;
    cfg_bht_en = 1;
    miss_en = 0;
    slow = 0;
    k = 0;
    drive(1);
    repeat (8) @(negedge core_clk);
    cmp(fetch_valid_r === 1'b0 && fetch_addr_r === `FBP_RST_ADDR
      && fetch_cnt_r === 3'h4 && fill_req_r === 1'b0, "reset");
    sys_rst = 0;
    for (int p = 0; p < 2; p++) begin
      cfg_bht_en = p == 0;
      repeat (400) begin
        @(negedge core_clk);
        check();
        drive(0);
      end
      $display("random test %0d done", p);
      fill(p == 1);
    end
    stop_test();
  end
endmodule
`default_nettype wire
